// file: logic/dac_update_reset_control.sv
// update, mask, reset and setup control for an eight-channel dac
`timescale 1ns/1ns
module dac_update_reset_control
    import dac_ctrl_pkg::*;
#(
    parameter int   CHANNELS       = NUM_CHANNELS,
    parameter int   WIDTH          = CODE_WIDTH,
    parameter int   POR_COUNT      = POR_CYCLES,
    parameter logic HAS_LEVEL_PIN  = 1'b1,
    parameter logic HAS_GAIN_PIN   = 1'b1
) (
    // system clock and power-on reset
    input  wire logic                      clock_in,
    input  wire logic                      reset_n_in,
    // serial link
    input  wire logic                      sclk_in,
    input  wire logic                      frame_select_n_in,
    input  wire logic                      sdi_in,
    // control pins
    input  wire logic                      load_strobe_n_in,
    input  wire logic                      hw_reset_n_in,
    input  wire logic                      clear_level_select_in,
    input  wire logic                      gain_pin_in,
    // channel, setup and power-on status outputs
    output logic      [CHANNELS*WIDTH-1:0] dac_code_out,
    output logic      [CHANNELS*WIDTH-1:0] input_code_out,
    output logic      [CHANNELS-1:0]       load_pin_mask_out,
    output logic                           gain_two_out,
    output logic                           reference_off_out,
    output logic                           por_busy_out
);
    por_state_type             por_state_r;
    por_state_type             por_state_nxt;
    logic [15:0]               por_count_r;
    logic [WIDTH-1:0]          input_r [CHANNELS];
    logic [WIDTH-1:0]          dac_r   [CHANNELS];
    logic [CHANNELS-1:0]       load_pin_mask_r;
    logic                      gain_r;
    logic                      ref_off_r;
    logic                      strobe_prev_r;
    logic [2:0]                toggle_sync_r;
    logic [FRAME_BITS-1:0]     frame_link;
    logic                      toggle_link;
    logic                      strobe_s;
    logic                      hw_reset_s;
    logic                      clear_sel_s;
    frame_type                 frame;
    logic                      frame_ev;
    logic                      strobe_fall;
    logic                      por_active;
    logic                      blocked;
    logic                      clear_now;
    logic                      soft_key_ok;
    logic [WIDTH-1:0]          clear_code;
    logic [CHANNELS-1:0]       addr_hot;

    // one-hot channel decode from the address field (see R23)
    function automatic logic [CHANNELS-1:0] chan_decode(input logic [3:0] addr);
        logic [CHANNELS-1:0] hot;
        hot = '0;
        if (int'(addr) < CHANNELS)
            hot[addr[$clog2(CHANNELS)-1:0]] = 1'b1;
        return hot;
    endfunction

    frame_shifter u_shifter (
        .sclk_in           (sclk_in),
        .frame_select_n_in (frame_select_n_in),
        .sdi_in            (sdi_in),
        .frame_out         (frame_link),
        .frame_toggle_out  (toggle_link)
    );

    level_sync #(.WIDTH(3), .RESET_LEVEL(1'b1)) u_pin_sync (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .async_in   ({load_strobe_n_in, hw_reset_n_in, clear_level_select_in}),
        .sync_out   ({strobe_s, hw_reset_s, clear_sel_s})
    );

    // toggle crossing; frame words are stable long before the toggle lands
    always_ff @(posedge clock_in) begin
        if (!reset_n_in)
            toggle_sync_r <= 3'h0;
        else
            toggle_sync_r <= {toggle_sync_r[1:0], toggle_link};
    end

    assign frame_ev    = (toggle_sync_r[2] != toggle_sync_r[1]) && !por_active;
    assign frame       = frame_type'(frame_link);
    assign por_active  = (por_state_r == POR_RUN);
    assign strobe_fall = strobe_prev_r && !strobe_s && !por_active;        // see R12
    assign blocked     = !hw_reset_s && !por_active;                      // see R11
    assign soft_key_ok = frame.addr == SOFT_RESET_ADDR
                         && frame.data == SOFT_RESET_KEY;                  // see R17
    assign clear_now   = blocked || (frame_ev && frame.cmd == CMD_SOFT_RESET && soft_key_ok);
    // variant without the level pin always clears to zero (see R16)
    assign clear_code  = (HAS_LEVEL_PIN && clear_sel_s) ? WIDTH'(MID_CODE)
                                                         : WIDTH'(ZERO_CODE); // see R14
    assign addr_hot    = chan_decode(frame.addr);

    // power-on sequence: strobe and reset pins are ignored until it ends (see R12)
    always_comb begin
        por_state_nxt = por_state_r;
        if (por_state_r == POR_RUN && por_count_r == 16'(POR_COUNT))
            por_state_nxt = POR_DONE;
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            por_state_r <= POR_RUN;
            por_count_r <= 16'h0000;
        end else begin
            por_state_r <= por_state_nxt;
            if (por_active)
                por_count_r <= por_count_r + 16'h0001;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in)
            strobe_prev_r <= 1'b1;
        else
            strobe_prev_r <= strobe_s;
    end

    // mask and setup registers
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            load_pin_mask_r <= CHANNELS'(MASK_RESET);                     // see R2
            gain_r          <= GAIN_RESET;                                // see R19
            ref_off_r       <= REF_OFF_RESET;                             // see R20
        end else if (frame_ev && frame.cmd == CMD_LOAD_MASK) begin
            load_pin_mask_r <= frame.data[CHANNELS-1:0];                  // see R1
        end else if (frame_ev && frame.cmd == CMD_SETUP) begin
            gain_r          <= frame.data[GAIN_BIT];                      // see R18
            ref_off_r       <= frame.data[REF_OFF_BIT];                   // see R20
        end else if (frame_ev && frame.cmd == CMD_SOFT_RESET && soft_key_ok) begin
            load_pin_mask_r <= CHANNELS'(MASK_RESET);
            gain_r          <= GAIN_RESET;
            ref_off_r       <= REF_OFF_RESET;
        end
    end

    // per-channel input and dac registers
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        logic hit;
        logic strobe_low;
        logic strobe_load;
        logic write_in;
        logic load_dac_in;
        logic write_dac;

        assign hit         = addr_hot[ch];
        // held-low strobe overrides the mask (see R8); a set bit sees strobe high (see R3)
        assign strobe_low  = !strobe_s && !por_active;
        assign strobe_load = strobe_fall && !load_pin_mask_r[ch];         // see R7
        assign write_in    = frame_ev && hit && (frame.cmd == CMD_WRITE_INPUT
                                                  || frame.cmd == CMD_WRITE_UPDATE);
        assign write_dac   = frame_ev && hit && (frame.cmd == CMD_WRITE_UPDATE  // see R6
                                 || (frame.cmd == CMD_WRITE_INPUT && strobe_low)); // see R4
        assign load_dac_in = strobe_load
                             || (frame_ev && frame.cmd == CMD_UPDATE_DAC
                                 && frame.data[ch]);                      // see R5

        always_ff @(posedge clock_in) begin
            // reload through power-on: the synchronised select settles late (see R14)
            if (!reset_n_in || clear_now || por_active) begin
                input_r[ch] <= clear_code;                                // see R9
                dac_r[ch]   <= clear_code;                                // see R14
            end else begin
                // outputs hold until a write reaches them (see R10, R15)
                if (write_in)
                    input_r[ch] <= frame.data[WIDTH-1:0];
                if (write_dac)
                    dac_r[ch]   <= frame.data[WIDTH-1:0];
                else if (load_dac_in)
                    dac_r[ch]   <= input_r[ch];
            end
        end

        assign dac_code_out[ch*WIDTH +: WIDTH]   = dac_r[ch];
        assign input_code_out[ch*WIDTH +: WIDTH] = input_r[ch];
    end

    assign load_pin_mask_out = load_pin_mask_r;
    assign gain_two_out      = HAS_GAIN_PIN ? gain_pin_in : gain_r;        // see R21
    assign reference_off_out = ref_off_r;
    assign por_busy_out      = por_active;

    // assertions
    mask_load_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // see R1
        frame_ev && frame.cmd == CMD_LOAD_MASK && !blocked
        |=> load_pin_mask_r == $past(frame.data[CHANNELS-1:0]))
        else $error("mask not loaded");
    mask_reset_a: assert property (@(posedge clock_in) // see R2
        $rose(reset_n_in) |-> load_pin_mask_r == MASK_RESET)
        else $error("mask not cleared");
    masked_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // see R3
        strobe_fall && load_pin_mask_r[CHANNELS-1] && !frame_ev && !clear_now
        |=> $stable(dac_r[CHANNELS-1]))
        else $error("masked channel moved");
    strobe_load_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // see R7
        strobe_fall && !load_pin_mask_r[0] && !frame_ev && !clear_now
        |=> dac_r[0] == $past(input_r[0]))
        else $error("strobe load missed");
    block_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // see R11
        blocked |=> dac_r[0] == $past(clear_code))
        else $error("update while reset low");
    por_len_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // see R12
        por_active && por_count_r != 16'(POR_COUNT) |=> por_active)
        else $error("power-on too short");
    por_end_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // see R12
        !por_active |=> !por_active)
        else $error("power-on restarted");
    power_up_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // see R14
        por_active |=> dac_r[0] == $past(clear_code))
        else $error("power-up code wrong");
    soft_key_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // see R17
        frame_ev && frame.cmd == CMD_SOFT_RESET && !soft_key_ok && !blocked
        && !strobe_fall |=> $stable(dac_r[0]))
        else $error("bad key reset");
    write_upd_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // see R6
        frame_ev && frame.cmd == CMD_WRITE_UPDATE && addr_hot[0] && !clear_now
        |=> dac_r[0] == $past(frame.data[WIDTH-1:0]))
        else $error("write-update missed");
    gain_set_a: assert property (@(posedge clock_in) disable iff (!reset_n_in) // see R19
        frame_ev && frame.cmd == CMD_SETUP && !blocked
        |=> gain_r == $past(frame.data[GAIN_BIT]))
        else $error("gain bit not taken");

    strobe_cov_c: cover property (@(posedge clock_in) strobe_fall);
    soft_rst_c:   cover property (@(posedge clock_in) frame_ev && soft_key_ok
                                  && frame.cmd == CMD_SOFT_RESET);
    mask_cov_c:   cover property (@(posedge clock_in) frame_ev && frame.cmd == CMD_LOAD_MASK);
endmodule

// file: logic/dac_ctrl_pkg.sv
// constants and carrier types for the eight-channel dac update and reset control
// What this block does
// R1: command 0101 loads eight-bit load-pin mask
// R2: mask resets 0; clear bits follow strobe
// R3: set mask bit makes channel ignore strobe
// R4: 0001 writes input; dac only if strobe low
// R5: 0010 copies selected inputs into dac registers
// R6: 0011 writes input and dac register together
// R7: strobe falling edge loads unmasked dac registers
// R8: strobe held low ignores mask bits
// R9: reset pin clears outputs to selected level
// R10: cleared code holds until next write
// R11: no output updates while reset pin low
// R12: strobe and reset ignored during power-on
// R13: host releases reset pin by power-up end
// R14: power-up level zero or midscale by select
// R15: power-up level holds until valid write
// R16: variant without select clears to zero
// R17: 0110 soft reset only with key 0x0/0x1234
// R18: 0111 writes setup from frame low bits
// R19: setup bit two selects gain one or two
// R20: setup bit zero disables internal reference
// R21: gain from setup bit only without gain pin
// R22: 24-bit frame takes effect on select rise
// R23: address bits pick the channel
// R24: strobe and reset pin pass two-flop synchroniser
package dac_ctrl_pkg;
    localparam int FRAME_BITS      = 24;
    localparam int CMD_MSB         = 23;
    localparam int CMD_LSB         = 20;
    localparam int ADDR_MSB        = 19;
    localparam int ADDR_LSB        = 16;
    localparam int DATA_MSB        = 15;
    localparam int DATA_LSB        = 0;
    localparam int GAIN_BIT        = 2;
    localparam int REF_OFF_BIT     = 0;
    localparam int NUM_CHANNELS    = 8;
    localparam int CODE_WIDTH      = 16;

    localparam logic [3:0]  CMD_WRITE_INPUT  = 4'h1;
    localparam logic [3:0]  CMD_UPDATE_DAC   = 4'h2;
    localparam logic [3:0]  CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0]  CMD_LOAD_MASK    = 4'h5;
    localparam logic [3:0]  CMD_SOFT_RESET   = 4'h6;
    localparam logic [3:0]  CMD_SETUP        = 4'h7;
    localparam logic [3:0]  SOFT_RESET_ADDR  = 4'h0;
    localparam logic [15:0] SOFT_RESET_KEY   = 16'h1234;

    localparam logic [7:0]  MASK_RESET       = 8'h00;
    localparam logic [15:0] ZERO_CODE        = 16'h0000;
    localparam logic [15:0] MID_CODE         = 16'h8000;
    localparam logic        GAIN_RESET       = 1'b0;
    localparam logic        REF_OFF_RESET    = 1'b0;

    // power-on sequence length in system clocks
    localparam int POR_TIME_NS     = 1000;
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int POR_CYCLES      = (POR_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SYNC_STAGES     = 2;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [3:0]  addr;
        logic [15:0] data;
    } frame_type;

    typedef enum logic [1:0] {
        POR_RUN  = 2'b00,
        POR_DONE = 2'b01
    } por_state_type;
endpackage

// file: logic/level_sync.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
module level_sync
    import dac_ctrl_pkg::*;
#(
    parameter int   WIDTH      = 1,
    parameter logic RESET_LEVEL = 1'b1
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             reset_n_in,
    // level in and out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // first stage feeds only the second stage (see R24)
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            meta_r <= {WIDTH{RESET_LEVEL}};
            sync_r <= {WIDTH{RESET_LEVEL}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// file: logic/frame_shifter.sv
// serial frame shifter on the link clock with toggle handoff
`timescale 1ns/1ns
module frame_shifter
    import dac_ctrl_pkg::*;
(
    // serial link
    input  wire logic                  sclk_in,
    input  wire logic                  frame_select_n_in,
    input  wire logic                  sdi_in,
    // captured frame to the system domain
    output logic      [FRAME_BITS-1:0] frame_out,
    output logic                       frame_toggle_out
);
    logic [FRAME_BITS-1:0] shift_r;
    // no reset reaches the link domain, so start values come from the declarations
    logic [4:0]            count_r  = 5'h00;
    logic                  toggle_r = 1'b0;
    logic [FRAME_BITS-1:0] frame_r;

    // link clock may stop between frames, so the counter restarts when select is high
    always_ff @(posedge sclk_in or posedge frame_select_n_in) begin
        if (frame_select_n_in) begin
            count_r <= 5'h00;
        end else begin
            shift_r <= {shift_r[FRAME_BITS-2:0], sdi_in};
            if (count_r != 5'(FRAME_BITS))
                count_r <= count_r + 5'h01;
        end
    end

    // frame latched by select rising; short frames are dropped (see R22)
    always_ff @(posedge frame_select_n_in) begin
        if (count_r == 5'(FRAME_BITS)) begin
            frame_r  <= shift_r;
            toggle_r <= ~toggle_r;
        end
    end

    assign frame_out        = frame_r;
    assign frame_toggle_out = toggle_r;
endmodule

// file: sim/host_model.sv
// host controller model: sends 24-bit serial frames on a gated link clock
`timescale 1ns/1ns
module host_model;
    // serial link driven toward the device
    logic sclk_out;
    logic frame_select_n_out;
    logic sdi_out;

    initial begin
        sclk_out           = 1'b0;
        frame_select_n_out = 1'b1;
        sdi_out            = 1'b0;
    end

    // link clock only runs inside a frame; data moves on the falling edge
    task automatic send_frame(input logic [23:0] word);
        #7;
        frame_select_n_out = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi_out = word[i];
            #40 sclk_out = 1'b1;
            #40 sclk_out = 1'b0;
        end
        #40 frame_select_n_out = 1'b1;
        // released line shows the inverse, not a stale bit
        sdi_out = ~sdi_out;
    endtask
endmodule

// file: sim/dac_update_reset_control_tb_top.sv
// self-checking bench for the dac update and reset control
`timescale 1ns/1ns
module dac_update_reset_control_tb_top
    import dac_ctrl_pkg::*;
;
    typedef struct {
        logic        strobe_n;
        logic [23:0] frame;
        int          ch;
        logic [15:0] exp_in;
        logic [15:0] exp_dac;
        logic [7:0]  exp_mask;
    } row_type;

    logic         clock_in;
    logic         reset_n_in;
    logic         load_strobe_n_in;
    logic         hw_reset_n_in;
    logic         clear_level_select_in;
    logic [127:0] dac_code_out;
    logic [127:0] input_code_out;
    logic [7:0]   load_pin_mask_out;
    logic         gain_two_out;
    logic         reference_off_out;
    logic         por_busy_out;
    int           error_cnt = 0;
    int           cmp_count = 0;

    row_type rows [0:10] = '{
        '{1'b1, 24'h101111, 0, 16'h1111, 16'h8000, 8'h00},
        '{1'b1, 24'h312222, 1, 16'h2222, 16'h2222, 8'h00},
        '{1'b1, 24'h200001, 0, 16'h1111, 16'h1111, 8'h00},
        '{1'b1, 24'h177777, 7, 16'h7777, 16'h8000, 8'h00},
        '{1'b1, 24'h133333, 3, 16'h3333, 16'h8000, 8'h00},
        '{1'b1, 24'h199999, 1, 16'h2222, 16'h2222, 8'h00},
        '{1'b1, 24'h5F0080, 7, 16'h7777, 16'h8000, 8'h80},
        '{1'b0, 24'h124444, 3, 16'h3333, 16'h3333, 8'h80},
        '{1'b0, 24'h5F0080, 7, 16'h7777, 16'h8000, 8'h80},
        '{1'b0, 24'h124444, 2, 16'h4444, 16'h4444, 8'h80},
        '{1'b0, 24'h175555, 7, 16'h5555, 16'h5555, 8'h80}
    };

    host_model i_host_model ();

    dac_update_reset_control #(
        .POR_COUNT    (4),
        .HAS_GAIN_PIN (1'b0)
    ) i_dac_update_reset_control (
        .clock_in              (clock_in),
        .reset_n_in            (reset_n_in),
        .sclk_in               (i_host_model.sclk_out),
        .frame_select_n_in     (i_host_model.frame_select_n_out),
        .sdi_in                (i_host_model.sdi_out),
        .load_strobe_n_in      (load_strobe_n_in),
        .hw_reset_n_in         (hw_reset_n_in),
        .clear_level_select_in (clear_level_select_in),
        .gain_pin_in           (1'b0),
        .dac_code_out          (dac_code_out),
        .input_code_out        (input_code_out),
        .load_pin_mask_out     (load_pin_mask_out),
        .gain_two_out          (gain_two_out),
        .reference_off_out     (reference_off_out),
        .por_busy_out          (por_busy_out)
    );

    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    // frame plus a settle time well past the 2..3 cycle handoff
    task automatic frame(input logic [23:0] word);
        i_host_model.send_frame(word);
        repeat (10) @(negedge clock_in);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #300000;
        error_cnt++;
        summarize();
    end

    initial begin
        int n;
        reset_n_in            = 1'b0;
        load_strobe_n_in      = 1'b1;
        hw_reset_n_in         = 1'b1;
        clear_level_select_in = 1'b1;
        repeat (8) @(negedge clock_in);
        reset_n_in = 1'b1;
        n = 0;
        while (por_busy_out !== 1'b0 && n < 100) begin
            @(negedge clock_in);
            n++;
        end
        repeat (2) @(negedge clock_in);
        check("por_busy", 128'h0, {127'h0, por_busy_out});
        check("power_up_codes", {8{16'h8000}}, dac_code_out);
        check("mask_reset", 128'h0, {120'h0, load_pin_mask_out});
        check("gain_reset", 128'h0, {127'h0, gain_two_out});
        check("ref_reset", 128'h0, {127'h0, reference_off_out});
        foreach (rows[i]) begin
            load_strobe_n_in = rows[i].strobe_n;
            repeat (6) @(negedge clock_in);
            frame(rows[i].frame);
            check("row_input", {112'h0, rows[i].exp_in},
                  {112'h0, input_code_out[16*rows[i].ch +: 16]});
            check("row_dac", {112'h0, rows[i].exp_dac},
                  {112'h0, dac_code_out[16*rows[i].ch +: 16]});
            check("row_mask", {120'h0, rows[i].exp_mask}, {120'h0, load_pin_mask_out});
        end
        load_strobe_n_in = 1'b1;
        // wrong key or wrong address must not reset
        frame(24'h601235);
        frame(24'h611234);
        check("soft_reset_bad_key", 128'h4444, {112'h0, dac_code_out[47:32]});
        frame(24'h601234);
        check("soft_reset_codes", {8{16'h8000}}, dac_code_out);
        check("soft_reset_mask", 128'h0, {120'h0, load_pin_mask_out});
        frame(24'h7FFFFD);
        check("gain_set", 128'h1, {127'h0, gain_two_out});
        check("ref_off_set", 128'h1, {127'h0, reference_off_out});
        frame(24'h700000);
        check("gain_clear", 128'h0, {127'h0, gain_two_out});
        check("ref_on", 128'h0, {127'h0, reference_off_out});
        clear_level_select_in = 1'b0;
        hw_reset_n_in         = 1'b0;
        repeat (10) @(negedge clock_in);
        check("hw_reset_zero", 128'h0, dac_code_out);
        frame(24'h31BEEF);
        check("hw_reset_blocks", 128'h0, dac_code_out);
        hw_reset_n_in = 1'b1;
        repeat (10) @(negedge clock_in);
        check("hw_reset_hold", 128'h0, dac_code_out);
        frame(24'h30ABCD);
        check("write_after_reset", 128'hABCD, {112'h0, dac_code_out[15:0]});
        // second power-on with the level select low must come up at zero scale
        frame(24'h5000FF);
        reset_n_in = 1'b0;
        repeat (8) @(negedge clock_in);
        reset_n_in = 1'b1;
        repeat (12) @(negedge clock_in);
        check("por_busy_again", 128'h0, {127'h0, por_busy_out});
        check("power_up_zero", 128'h0, dac_code_out);
        check("mask_reset_again", 128'h0, {120'h0, load_pin_mask_out});
        summarize();
    end
endmodule
